// file: isd_i2c_master.sv
// I2C bus master model with open-drain SCL and SDA drivers.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module isd_i2c_master (
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_oe_n,
	output logic      o_sda_oe_n
);
	logic stretched;
	logic unstable;
	logic hung;
	initial begin
		o_scl_oe_n = 1'b1;
		o_sda_oe_n = 1'b1;
		stretched  = 1'b0;
		unstable   = 1'b0;
		hung       = 1'b0;
	end
	// One bit: SDA set in low phase, sampled at rise and again halfway through high
	task automatic clk_bit(input logic b, output logic s);
		o_sda_oe_n = b;
		#42.5 o_scl_oe_n = 1'b1;
		for (int i = 0; i < 400 && !i_scl; i++) begin
			stretched = 1'b1;
			#10;
		end
		if (!i_scl) hung = 1'b1;
		s = i_sda;
		#31;
		if (i_sda !== s) unstable = 1'b1;
		#31.5 o_scl_oe_n = 1'b0;
		#20;
	endtask : clk_bit
	task automatic start;
		o_sda_oe_n = 1'b1;
		#62.5 o_scl_oe_n = 1'b1;
		#62.5 o_sda_oe_n = 1'b0;
		#62.5 o_scl_oe_n = 1'b0;
		#20;
	endtask : start
	task automatic stop;
		o_sda_oe_n = 1'b0;
		#62.5 o_scl_oe_n = 1'b1;
		#62.5 o_sda_oe_n = 1'b1;
		#125;
	endtask : stop
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask : wr
	task automatic rd(input logic nak, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(nak, s);
	endtask : rd
endmodule : isd_i2c_master
`default_nettype wire

// file: isd_pkg.sv
// Constants shared by the I2C slave with its SRAM window access path.
// Assumes a byte-wide SRAM port with an 11-bit byte address.
package isd_pkg;
	localparam int unsigned ISD_DEV_ADDR_W = 7;
	// Slave address: value arbitrary, stands for the factory-set address
	localparam logic [6:0]  ISD_DEV_ADDR   = 7'h2a;
	localparam int unsigned ISD_BYTE_W     = 8;
	localparam int unsigned ISD_PTR_W      = 8;
	localparam int unsigned ISD_MEM_AW     = 11;
	localparam int unsigned ISD_BASE_W     = ISD_MEM_AW - ISD_PTR_W;
	localparam int unsigned ISD_FIFO_DEPTH = 4;
	localparam logic [3:0]  ISD_BITS_BYTE  = 4'h8;
	localparam logic [2:0]  ISD_LAST_FALL  = 3'h7;
	localparam logic [7:0]  ISD_IDLE_BYTE  = 8'hff;
	localparam logic [1:0]  ISD_CRED_ONE   = 2'h1;

	typedef enum logic [8:0] {
		ISD_IDLE  = 9'h001,
		ISD_ADDR  = 9'h002,
		ISD_AACK  = 9'h004,
		ISD_WBYTE = 9'h008,
		ISD_WACK  = 9'h010,
		ISD_RBYTE = 9'h020,
		ISD_RWAIT = 9'h040,
		ISD_RACK  = 9'h080,
		ISD_SKIP  = 9'h100
	} isd_state_t;
endpackage : isd_pkg

// file: isd_slave.sv
// I2C slave with direct byte access to a 256-byte SRAM window.
// Assumes open-drain SCL/SDA resolved outside; SRAM read data arrives one cycle after grant.
// Behaviour
// - Own address match raises a wake pulse for the stopped core.
// - Hold SCL low while a received byte or next send byte is not ready.
// - Without stretching, drive ACK low only when ready, stable through SCL high.
// - A declined data byte leaves SDA released during its acknowledge bit.
// - Transfers reach a 256-byte window placed on any 256-byte boundary in 2 KB.
// - First written byte after an initial START loads the pointer.
// - Initial START is the first after reset or the first after STOP.
// - Later bytes go to or from SRAM at the pointer, which then increments.
// - Read-ahead fetching starts in address ACK and runs until FIFO full.
// - Read-ahead fetches another byte whenever the master takes one.
// - Unsent bytes stay in the FIFO until firmware flushes them.
// - EEPROM mode fetches one byte at address ACK, one per master ACK.
// - EEPROM mode starts no fetch after a master NACK.
// - SRAM write launches during the ACK bit of a complete byte.
// - Pointer wraps freely; no bounds checking on the written address.
`timescale 1ns/1ps
`default_nettype none
module isd_slave
	import isd_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR   = ISD_DEV_ADDR,
	parameter int unsigned FIFO_DEPTH = ISD_FIFO_DEPTH
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_scl,
	output logic                       o_scl_o,
	output logic                       o_scl_oe_n,
	input  wire logic                  i_sda,
	output logic                       o_sda_o,
	output logic                       o_sda_oe_n,
	input  wire logic                  i_stretch_en,
	input  wire logic                  i_eeprom_mode,
	input  wire logic [ISD_BASE_W-1:0] i_win_base,
	input  wire logic                  i_fifo_flush,
	output logic                       o_wake,
	output logic [ISD_PTR_W-1:0]       o_ptr,
	output logic                       o_mem_req,
	output logic                       o_mem_we,
	output logic [ISD_MEM_AW-1:0]      o_mem_addr,
	output logic [ISD_BYTE_W-1:0]      o_mem_wdata,
	input  wire logic                  i_mem_gnt,
	input  wire logic [ISD_BYTE_W-1:0] i_mem_rdata
);
	logic       scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	isd_state_t st_q;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic [7:0] ptr_q;
	logic [1:0] cred_q;
	logic       rw_q, ack_ok_q, init_q, first_q, ptr_load_q, mack_q;
	logic       wr_pend_q, wdone_q, rd_pend_q, infl_q, ra_act_q, wake_q;
	logic       fifo_nfull, fifo_nempty;
	logic [7:0] fifo_dout;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
		end
	end

	wire scl_rise  = scl_s_q && !scl_p_q;
	wire scl_fall  = !scl_s_q && scl_p_q;
	wire start_c   = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	wire stop_c    = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	wire in_ack    = (st_q == ISD_AACK) || (st_q == ISD_WACK);
	wire addr_hit  = (sh_q[7:1] == DEV_ADDR);
	wire addr_done = (st_q == ISD_ADDR) && scl_fall && (cnt_q == ISD_BITS_BYTE);
	wire wr_done   = (st_q == ISD_WBYTE) && scl_fall && (cnt_q == ISD_BITS_BYTE);
	wire load_now  = scl_fall && (((st_q == ISD_AACK) && ack_ok_q && rw_q) ||
	                 ((st_q == ISD_RACK) && mack_q));
	wire rwait_go  = (st_q == ISD_RWAIT) && fifo_nempty;
	wire fifo_pop  = (load_now || rwait_go) && fifo_nempty;
	wire mem_take  = o_mem_req && i_mem_gnt;
	wire mack_inc  = (st_q == ISD_RACK) && scl_rise && !sda_s_q && i_eeprom_mode;
	wire want_rd   = (ra_act_q || cred_q != '0) && fifo_nfull && !rd_pend_q &&
	                 !infl_q && !wr_pend_q;
	wire ack_rdy   = (st_q == ISD_AACK) ? (addr_hit && (!rw_q || i_stretch_en || fifo_nempty)) :
	                 wdone_q;
	wire [1:0] cred_d = cred_q + {1'b0, mack_inc} - {1'b0, want_rd && !ra_act_q};

	assign o_scl_o     = 1'b0;
	assign o_sda_o     = 1'b0;
	// Hold SCL until the ACK level already stands on SDA, or in ISD_RWAIT until a send byte is in the FIFO
	assign o_scl_oe_n  = !(i_stretch_en && (((st_q == ISD_WACK) && !ack_ok_q) ||
	                     (st_q == ISD_RWAIT)));
	assign o_sda_oe_n  = in_ack ? !ack_ok_q : ((st_q == ISD_RBYTE) ? sh_q[7] : 1'b1);
	assign o_wake      = wake_q;
	assign o_ptr       = ptr_q;
	assign o_mem_req   = wr_pend_q || rd_pend_q;
	assign o_mem_we    = wr_pend_q;
	assign o_mem_addr  = {i_win_base, ptr_q};
	assign o_mem_wdata = sh_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q       <= ISD_IDLE;
			sh_q       <= '0;
			cnt_q      <= '0;
			rw_q       <= 1'b0;
			ack_ok_q   <= 1'b0;
			init_q     <= 1'b1;
			first_q    <= 1'b0;
			ptr_load_q <= 1'b0;
			mack_q     <= 1'b0;
			wake_q     <= 1'b0;
			ra_act_q   <= 1'b0;
			wdone_q    <= 1'b0;
		end else begin
			wake_q <= 1'b0;
			if (in_ack && !scl_s_q && ack_rdy)
				ack_ok_q <= 1'b1;
			if (scl_fall)
				ack_ok_q <= 1'b0;
			if (mem_take && wr_pend_q)
				wdone_q <= 1'b1;
			if (start_c) begin
				st_q     <= ISD_ADDR;
				cnt_q    <= '0;
				first_q  <= init_q;
				init_q   <= 1'b0;
				ra_act_q <= 1'b0;
			end else if (stop_c) begin
				st_q     <= ISD_IDLE;
				init_q   <= 1'b1;
				ra_act_q <= 1'b0;
			end else begin
				case (st_q)
				ISD_ADDR, ISD_WBYTE: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s_q};
						cnt_q <= cnt_q + 1'b1;
					end
					if (addr_done) begin
						st_q       <= ISD_AACK;
						rw_q       <= sh_q[0];
						wake_q     <= addr_hit;
						ptr_load_q <= addr_hit && !sh_q[0] && first_q;
						ra_act_q   <= addr_hit && sh_q[0] && !i_eeprom_mode;
					end
					if (wr_done) begin
						st_q <= ISD_WACK;
						if (ptr_load_q) begin
							ptr_load_q <= 1'b0;
							wdone_q    <= 1'b1;
						end else
							wdone_q <= 1'b0;
					end
				end
				ISD_AACK, ISD_WACK, ISD_RACK: begin
					if (scl_rise)
						mack_q <= !sda_s_q;
					if (scl_fall) begin
						cnt_q <= '0;
						if (load_now) begin
							st_q <= (fifo_nempty || !i_stretch_en) ? ISD_RBYTE : ISD_RWAIT;
							sh_q <= fifo_nempty ? fifo_dout : ISD_IDLE_BYTE;
						end else if (ack_ok_q && !rw_q)
							st_q <= ISD_WBYTE;
						else
							st_q <= ISD_SKIP;
					end
				end
				ISD_RWAIT: begin
					if (fifo_nempty) begin
						st_q <= ISD_RBYTE;
						sh_q <= fifo_dout;
					end
				end
				ISD_RBYTE: begin
					if (scl_fall) begin
						sh_q  <= {sh_q[6:0], 1'b1};
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q[2:0] == ISD_LAST_FALL)
							st_q <= ISD_RACK;
					end
				end
				ISD_IDLE, ISD_SKIP: begin
					cnt_q <= '0;
				end
				default: st_q <= ISD_IDLE;
				endcase
			end
		end
	end

	// SRAM access engine shared by writes and fetches
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_q     <= '0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			infl_q    <= 1'b0;
			cred_q    <= '0;
		end else begin
			infl_q <= mem_take && rd_pend_q;
			cred_q <= cred_d;
			if (addr_done)
				cred_q <= (addr_hit && sh_q[0] && i_eeprom_mode) ? ISD_CRED_ONE : '0;
			if (wr_done && ptr_load_q)
				ptr_q <= sh_q;
			else if (mem_take)
				ptr_q <= ptr_q + 1'b1;
			if (want_rd)
				rd_pend_q <= 1'b1;
			else if (mem_take)
				rd_pend_q <= 1'b0;
			if (wr_done && !ptr_load_q)
				wr_pend_q <= 1'b1;
			else if (mem_take || start_c || stop_c || ((st_q == ISD_WACK) && scl_rise))
				wr_pend_q <= 1'b0;
		end
	end

	isd_tx_fifo #(
		.WIDTH (ISD_BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_flush    (i_fifo_flush),
		.i_wr_valid (infl_q),
		.o_wr_ready (fifo_nfull),
		.i_din      (i_mem_rdata),
		.o_rd_valid (fifo_nempty),
		.i_rd_ready (fifo_pop),
		.o_dout     (fifo_dout)
	);

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	chk_wake_match: assert property (o_wake |-> st_q == ISD_AACK && addr_hit)
		else $error("wake without own address");
	chk_scl_hold: assert property (!o_scl_oe_n |-> i_stretch_en && !scl_s_q || $past(!o_scl_oe_n))
		else $error("SCL hold begun while SCL high or stretching off");
	chk_ack_stable: assert property (in_ack && scl_s_q && $past(scl_s_q) |-> $stable(o_sda_oe_n))
		else $error("ACK level moved during SCL high");
	chk_nack_free: assert property ((st_q == ISD_WACK) && !wdone_q |-> o_sda_oe_n)
		else $error("ACK driven before byte stored");
	chk_first_start: assert property (start_c && !init_q |=> !first_q)
		else $error("repeated START taken as initial");
	chk_ptr_load: assert property (wr_done && ptr_load_q |=> ptr_q == $past(sh_q) && !wr_pend_q)
		else $error("pointer byte not loaded");
	chk_ptr_incr: assert property (mem_take && !(wr_done && ptr_load_q) |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer not advanced after access");
	chk_wr_in_ack: assert property (wr_pend_q |-> st_q == ISD_WACK)
		else $error("SRAM write outside acknowledge bit");
	chk_eep_nack: assert property (i_eeprom_mode && (st_q == ISD_RACK) && scl_rise && sda_s_q
		|=> cred_q <= $past(cred_q))
		else $error("fetch credit after master NACK");
	chk_ra_fill: assert property (ra_act_q && fifo_nfull && !rd_pend_q && !infl_q && !wr_pend_q
		|=> rd_pend_q)
		else $error("read-ahead stalled with FIFO room");
endmodule : isd_slave
`default_nettype wire

// file: isd_tx_fifo.sv
// Transmit FIFO holding bytes fetched from SRAM for the read direction.
// Assumes push and pop come from the same clock; flush empties it at once.
`timescale 1ns/1ps
`default_nettype none
module isd_tx_fifo
	import isd_pkg::*;
#(
	parameter int unsigned WIDTH = ISD_BYTE_W,
	parameter int unsigned DEPTH = ISD_FIFO_DEPTH
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_flush,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_din,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic      [WIDTH-1:0] o_dout
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST   = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	wire              do_wr = i_wr_valid && o_wr_ready;
	wire              do_rd = i_rd_ready && o_rd_valid;

	assign o_wr_ready = (cnt_q != FULL_CNT);
	assign o_rd_valid = (cnt_q != '0);
	assign o_dout     = mem_q[rp_q];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_ent
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n)
					mem_q[g] <= '0;
				else if (do_wr && wp_q == AW'(g))
					mem_q[g] <= i_din;
			end
		end
	endgenerate

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (i_flush) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr)
				wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
			if (do_rd)
				rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : isd_tx_fifo
`default_nettype wire

// file: tb.sv
// Testbench for the I2C slave with SRAM window access.
// Assumes the master model and a behavioural SRAM with stallable grant.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import isd_pkg::*;
	logic       clk = 1'b0, rst_n = 1'b0, stretch = 1'b1, eep = 1'b0;
	logic       flush = 1'b0, gnt = 1'b0, stall = 1'b0;
	logic [2:0] base = 3'h5;
	logic [7:0] rdata = 8'h00, rd_n = 8'h00;
	logic [7:0] mem [0:2047];
	wire logic  m_scl_oe_n, m_sda_oe_n, s_scl_oe_n, s_sda_oe_n, s_scl_o, s_sda_o, wake, req, we;
	wire logic [7:0]  ptr, wdata;
	wire logic [10:0] addr;
	wire scl = m_scl_oe_n & (s_scl_oe_n | s_scl_o);
	wire sda = m_sda_oe_n & (s_sda_oe_n | s_sda_o);
	int error_cnt = 0, n_tests = 0, rd_cnt = 0, wake_cnt = 0, n0 = 0;
	always #5 clk = ~clk;
	isd_i2c_master m (.i_scl(scl), .i_sda(sda), .o_scl_oe_n(m_scl_oe_n), .o_sda_oe_n(m_sda_oe_n));
	isd_slave #(.DEV_ADDR(ISD_DEV_ADDR), .FIFO_DEPTH(ISD_FIFO_DEPTH)) dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .o_scl_o(s_scl_o),
		.o_scl_oe_n(s_scl_oe_n), .i_sda(sda), .o_sda_o(s_sda_o), .o_sda_oe_n(s_sda_oe_n),
		.i_stretch_en(stretch), .i_eeprom_mode(eep), .i_win_base(base), .i_fifo_flush(flush),
		.o_wake(wake), .o_ptr(ptr), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr),
		.o_mem_wdata(wdata), .i_mem_gnt(gnt), .i_mem_rdata(rdata));
	// SRAM: grant one access at a time, read data the cycle after grant
	always @(posedge clk) begin
		if (req && gnt && we) mem[addr] <= wdata;
		if (req && gnt && !we) begin
			rd_n   <= mem[addr];
			rd_cnt <= rd_cnt + 1;
		end
		if (wake) wake_cnt <= wake_cnt + 1;
	end
	always @(negedge clk) begin
		gnt   <= req & ~gnt & ~stall;
		rdata <= rd_n;
	end
	task automatic cmp_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input string nm, input logic exp, input logic got);
		cmp_byte(nm, {7'h0, exp}, {7'h0, got});
	endtask : cmp_bit
	task automatic addr_b(input logic [6:0] a, input logic r, input logic exp_ack);
		logic ack;
		m.start();
		m.wr({a, r}, ack);
		cmp_bit("address ack", exp_ack, ack);
	endtask : addr_b
	task automatic wb(input logic [7:0] d, input logic exp_ack);
		logic ack;
		m.wr(d, ack);
		cmp_bit("data ack", exp_ack, ack);
	endtask : wb
	task automatic rb(input logic nak, input logic [7:0] exp);
		logic [7:0] d;
		m.rd(nak, d);
		cmp_byte("read byte", exp, d);
	endtask : rb
	task automatic results;
		$display("Checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	initial begin
		for (int i = 0; i < 90000 && m.hung !== 1'b1; i++) @(posedge clk);
		error_cnt++;
		results();
	end
	initial begin
		for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5a;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Pointer load then writes wrapping inside window 5
		addr_b(ISD_DEV_ADDR, 1'b0, 1'b1);
		wb(8'hfe, 1'b1);
		wb(8'ha1, 1'b1);
		wb(8'ha2, 1'b1);
		wb(8'ha3, 1'b1);
		cmp_byte("mem 5fe", 8'ha1, mem[11'h5fe]);
		cmp_byte("mem 500", 8'ha3, mem[11'h500]);
		cmp_byte("pointer", 8'h01, ptr);
		cmp_byte("wakes", 8'h01, 8'(wake_cnt));
		addr_b(ISD_DEV_ADDR, 1'b0, 1'b1);
		wb(8'hb4, 1'b1);
		cmp_byte("mem 501", 8'hb4, mem[11'h501]);
		m.stop();
		addr_b(7'h33, 1'b0, 1'b0);
		wb(8'h00, 1'b0);
		m.stop();
		cmp_byte("wakes", 8'h02, 8'(wake_cnt));
		// Read-ahead from 0x10, residue kept, then flushed
		addr_b(ISD_DEV_ADDR, 1'b0, 1'b1);
		wb(8'h10, 1'b1);
		n0 = rd_cnt;
		addr_b(ISD_DEV_ADDR, 1'b1, 1'b1);
		for (int i = 0; i < 3; i++) rb(i == 2, mem[11'h510 + i]);
		m.stop();
		cmp_byte("fetches", 8'(3 + ISD_FIFO_DEPTH), 8'(rd_cnt - n0));
		cmp_byte("pointer", 8'h17, ptr);
		addr_b(ISD_DEV_ADDR, 1'b1, 1'b1);
		rb(1'b1, mem[11'h513]);
		m.stop();
		@(negedge clk) flush = 1'b1;
		@(negedge clk) flush = 1'b0;
		@(negedge clk) eep = 1'b1;
		n0 = rd_cnt;
		addr_b(ISD_DEV_ADDR, 1'b1, 1'b1);
		rb(1'b0, mem[11'h518]);
		rb(1'b1, mem[11'h519]);
		m.stop();
		cmp_byte("fetches", 8'h02, 8'(rd_cnt - n0));
		// Stalled SRAM: stretch on, then ack polling with stretch off
		@(negedge clk) stall = 1'b1;
		addr_b(ISD_DEV_ADDR, 1'b0, 1'b1);
		wb(8'h20, 1'b1);
		m.stretched = 1'b0;
		fork
			wb(8'hc5, 1'b1);
			begin
				repeat (150) @(negedge clk);
				stall = 1'b0;
			end
		join
		cmp_bit("stretched", 1'b1, m.stretched);
		cmp_byte("mem 520", 8'hc5, mem[11'h520]);
		@(negedge clk) stretch = 1'b0;
		stall = 1'b1;
		wb(8'hd6, 1'b0);
		cmp_byte("mem 521", 8'h7b, mem[11'h521]);
		addr_b(ISD_DEV_ADDR, 1'b0, 1'b1);
		@(negedge clk) stall = 1'b0;
		wb(8'he7, 1'b1);
		m.stop();
		cmp_byte("mem 521", 8'he7, mem[11'h521]);
		cmp_bit("sda stable", 1'b0, m.unstable);
		results();
	end
endmodule : tb
`default_nettype wire
